// *** sldr_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module sldr_host_model #(
   parameter int SYM = 100
) (
   // Clock.
   input wire logic ref_clk,
   // Serial line towards the receiver.
   output var logic data_in
);
   // The line idles high between frames.
   initial data_in = 1'b1;

   // Holds one level for n clocks, optionally with a one-clock spike at its middle.
   task automatic hold(input logic lvl, input int n, input bit spike);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         data_in <= (spike && i == n / 2) ? ~lvl : lvl;
      end
   endtask

   // Sends the learning pulse, then each bit as a symbol pair, then a long idle.
   task automatic send_frame(input logic [7:0] b[$], input bit spike);
      hold(1'b0, SYM, 1'b0);
      foreach (b[k]) begin
         for (int j = 7; j >= 0; j--) begin
            hold(b[k][j], SYM, spike);
            hold(~b[k][j], SYM, spike);
         end
      end
      hold(1'b1, 6 * SYM, 1'b0);
   endtask
endmodule
`default_nettype wire

// *** sldr_pkg.sv ***
package sldr_pkg;
   // Channel and duty geometry.
   localparam int CHANNELS = 9;
   localparam int DUTY_W = 7;
   localparam logic [6:0] PWM_TOP = 7'h7F;
   localparam logic [6:0] DUTY_RESET = 7'h00;
   // Input filter: a level must persist this many clocks to be believed.
   localparam logic [1:0] GLITCH_CYCLES = 2'h2;
   // Clock and PWM timing; one PWM step is the 3 ms gap split into 128 steps.
   localparam int CLK_PERIOD_NS = 5;
   localparam int FRAME_GAP_US = 3000;
   localparam int PWM_STEPS_PER_GAP = 128;
   localparam int PWM_TICK_CYCLES = FRAME_GAP_US * 1000 / CLK_PERIOD_NS / PWM_STEPS_PER_GAP;
   // Line timing: frame ends after this many symbols with no edge.
   localparam logic [2:0] IDLE_END_SYMBOLS = 3'h4;
   localparam logic [10:0] MIN_SYMBOL = 11'h004;
   // Command bytes (decoded original byte values).
   localparam logic [7:0] CMD_ALL = 8'h20;
   localparam logic [7:0] CMD_SPECIAL = 8'h60;
   localparam int ADDR_LSB = 1;
   localparam int DUTY_LSB = 1;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_LEARN = 2'b01,
      PH_RECV = 2'b10
   } sldr_phase_t;

   // Three-level address pin, resolved outside to a code 0..2.
   typedef struct packed {
      logic [1:0] pin2;
      logic [1:0] pin1;
      logic [1:0] pin0;
   } sldr_id_pins_t;

   typedef struct packed {
      logic filt;
      logic [1:0] glitch;
      sldr_phase_t phase;
      logic [10:0] period;
      logic [10:0] cnt;
      logic [13:0] gap;
      logic [15:0] shift;
      logic [3:0] nbits;
      logic [3:0] nbytes;
      logic [3:0] chan;
      logic all_mode;
      logic special;
      logic frame_err;
      logic [5:0] my_id;
      logic id_valid;
      logic [CHANNELS-1:0][DUTY_W-1:0] shadow;
      logic [CHANNELS-1:0] written;
      logic [CHANNELS-1:0][DUTY_W-1:0] duty;
      logic pending;
      logic [12:0] tick;
      logic [6:0] pwm;
      logic [CHANNELS-1:0] led_on;
   } sldr_state_t;
endpackage

// *** sldr_receiver.sv ***
`timescale 1ns/100ps
`default_nettype none
module sldr_receiver #(
   parameter logic [12:0] PWM_TICK = 13'(sldr_pkg::PWM_TICK_CYCLES)
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Serial line and supervision inputs.
   input wire logic data_in,
   input wire logic power_good,
   input wire logic thermal_shutdown,
   input wire sldr_pkg::sldr_id_pins_t id_pins,
   // LED drive, high turns the channel's current sink on.
   output logic [sldr_pkg::CHANNELS-1:0] led_on
);
   import sldr_pkg::*;

   sldr_state_t s;
   sldr_state_t next_s;
   logic [CHANNELS-1:0] next_led;

   // Decodes sixteen line symbols into a byte; a pair of equal symbols is an error.
   function automatic logic [8:0] decode_pairs(input logic [15:0] sym);
      logic [8:0] r;
      r = 9'h000;
      for (int b = 0; b < 8; b++) begin
         r[b] = sym[2*b+1];
         if (sym[2*b+1] == sym[2*b]) begin
            r[8] = 1'b1;
         end
      end
      return r;
   endfunction

   // Per channel PWM comparison, forced off in thermal shutdown.
   generate
      for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
         assign next_led[i] = !thermal_shutdown && (s.pwm < s.duty[i]);
      end
   endgenerate

   // Next-state logic for the whole receiver.
   always_comb begin
      logic new_filt;
      logic edge_seen;
      logic take_sym;
      logic [8:0] dec;
      logic frame_end;
      logic pwm_wrap;
      next_s = s;
      new_filt = s.filt;
      edge_seen = 1'b0;
      take_sym = 1'b0;
      dec = 9'h000;
      frame_end = 1'b0;
      pwm_wrap = 1'b0;

      // Glitch filter: a new level must hold for two clocks.
      if (data_in != s.filt) begin
         next_s.glitch = s.glitch + 2'h1;
         if (s.glitch + 2'h1 >= GLITCH_CYCLES) begin
            new_filt = data_in;
            edge_seen = 1'b1;
            next_s.glitch = 2'h0;
         end
      end else begin
         next_s.glitch = 2'h0;
      end
      next_s.filt = new_filt;

      // Address pins are captured once power is good.
      if (power_good && !s.id_valid) begin
         next_s.id_valid = 1'b1;
         next_s.my_id = {id_pins.pin2, id_pins.pin1, id_pins.pin0};
      end

      // PWM step timer and 7-bit counter.
      if (s.tick >= PWM_TICK - 13'h0001) begin
         next_s.tick = 13'h0000;
         next_s.pwm = s.pwm + 7'h01;
         pwm_wrap = (s.pwm == PWM_TOP);
      end else begin
         next_s.tick = s.tick + 13'h0001;
      end

      unique case (s.phase)
         PH_IDLE: begin
            next_s.period = 11'h000;
            if (edge_seen && !new_filt) begin
               next_s.phase = PH_LEARN;
               next_s.cnt = 11'h000;
            end
         end
         PH_LEARN: begin
            // The first low pulse is one symbol long.
            next_s.cnt = s.cnt + 11'h001;
            if (edge_seen) begin
               if (s.cnt >= MIN_SYMBOL) begin
                  next_s.phase = PH_RECV;
                  next_s.period = s.cnt + 11'h001;
                  next_s.cnt = 11'h000;
                  next_s.gap = 14'h0000;
                  next_s.nbits = 4'h0;
                  next_s.nbytes = 4'h0;
                  next_s.frame_err = 1'b0;
                  next_s.all_mode = 1'b0;
                  next_s.special = 1'b0;
                  next_s.chan = 4'h0;
                  if (!s.pending) begin
                     next_s.written = '0;
                  end
               end else begin
                  next_s.phase = PH_IDLE;
               end
            end else if (&s.cnt) begin
               next_s.phase = PH_IDLE;
            end
         end
         PH_RECV: begin
            // Symbol clock resyncs on each edge and samples mid-symbol.
            next_s.cnt = edge_seen ? 11'h000 : s.cnt + 11'h001;
            if (!edge_seen && s.cnt + 11'h001 >= s.period) begin
               next_s.cnt = 11'h000;
            end
            next_s.gap = edge_seen ? 14'h0000 : s.gap + 14'h0001;
            take_sym = !edge_seen && (s.cnt == (s.period >> 1));
            if (take_sym) begin
               next_s.shift = {s.shift[14:0], s.filt};
               next_s.nbits = s.nbits + 4'h1;
               if (s.nbits == 4'hF) begin
                  dec = decode_pairs({s.shift[14:0], s.filt});
                  next_s.nbytes = (s.nbytes == 4'hF) ? s.nbytes : s.nbytes + 4'h1;
                  if (dec[8]) begin
                     next_s.frame_err = 1'b1;
                  end else if (s.nbytes == 4'h1) begin
                     next_s.all_mode = (dec[7:0] == CMD_ALL);
                     next_s.special = (dec[7:0] == CMD_SPECIAL);
                     next_s.chan = (dec[7:0] == CMD_SPECIAL) ? 4'h0 : dec[4:1];
                  end else if (s.nbytes >= 4'h2 && !s.pending) begin
                     for (int c = 0; c < CHANNELS; c++) begin
                        // All mode broadcasts, but a byte past the ninth is still dropped.
                        if ((s.all_mode && s.chan < 4'(CHANNELS))
                            || s.chan == 4'(c)) begin
                           next_s.shadow[c] = dec[DUTY_LSB +: DUTY_W];
                           next_s.written[c] = 1'b1;
                        end
                     end
                     next_s.chan = (s.chan == 4'hF) ? s.chan : s.chan + 4'h1;
                  end else if (s.nbytes == 4'h0 && dec[ADDR_LSB +: 6] != s.my_id) begin
                     next_s.frame_err = 1'b1;
                  end
               end
            end
            // Long silence closes the frame and forgets the period.
            if (s.gap >= 14'({s.period, 2'b00}) + 14'(IDLE_END_SYMBOLS) - 14'h0004) begin
               next_s.phase = PH_IDLE;
               frame_end = 1'b1;
            end
         end
         default: begin
            next_s.phase = PH_IDLE;
         end
      endcase

      // Accept a complete frame for this address unless one is already waiting or the count is at 127; a special frame must write all nine channels.
      if (frame_end && s.id_valid && !s.frame_err && !s.pending && s.nbytes >= 4'h3
          && s.pwm != PWM_TOP && !(s.special && !(&s.written))) begin
         next_s.pending = 1'b1;
      end

      // Apply waiting values at count zero; unwritten channels keep theirs.
      if (pwm_wrap && s.pending) begin
         for (int c = 0; c < CHANNELS; c++) begin
            if (s.written[c]) begin
               next_s.duty[c] = s.shadow[c];
            end
         end
         next_s.pending = 1'b0;
      end

      next_s.led_on = next_led;
   end

   // State register.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign led_on = s.led_on;

   chk_shutdown_off: assert property (@(posedge ref_clk) disable iff (rst)
      thermal_shutdown |=> (led_on == '0))
      else $error("LED on during thermal shutdown");

   chk_id_gated: assert property (@(posedge ref_clk) disable iff (rst)
      !s.id_valid |-> !s.pending)
      else $error("Frame accepted before power good");

   chk_duty_at_zero: assert property (@(posedge ref_clk) disable iff (rst)
      (s.duty != $past(s.duty)) |-> (s.pwm == 7'h00 && $past(s.pending)))
      else $error("Duty changed away from count zero");

   chk_glitch_drop: assert property (@(posedge ref_clk) disable iff (rst)
      (data_in != s.filt && s.glitch == 2'h0) |=> $stable(s.filt))
      else $error("One clock pulse passed the filter");

   chk_held_chan: assert property (@(posedge ref_clk) disable iff (rst)
      (s.pending && !s.written[0]) ##1 !s.pending |-> $stable(s.duty[0]))
      else $error("Unwritten channel changed");

   chk_period_reset: assert property (@(posedge ref_clk) disable iff (rst)
      (s.phase == PH_RECV) ##1 (s.phase == PH_IDLE) |=> (s.period == 11'h000))
      else $error("Learned period kept after frame end");

   chk_no_late_accept: assert property (@(posedge ref_clk) disable iff (rst)
      (s.pwm == PWM_TOP && !s.pending) |=> !s.pending || $past(s.pwm) != PWM_TOP)
      else $error("Frame accepted at count 127");

   chk_led_follows: assert property (@(posedge ref_clk) disable iff (rst)
      (!thermal_shutdown && s.duty[1] == 7'h00) ##1 $stable(s.duty[1]) |-> !led_on[1])
      else $error("Zero duty channel lit");
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import sldr_pkg::*;
   localparam int PWM_LEN = 128 * 4;
   localparam logic [7:0] MY_ADDR = 8'hC8;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic power_good = 1'b0;
   logic thermal_shutdown = 1'b0;
   sldr_id_pins_t id_pins = 6'h24;
   wire logic data_in;
   logic [CHANNELS-1:0] led_on;
   logic [6:0] exp_duty [CHANNELS];
   int n_fail = 0;
   int samples_checked = 0;

   // Host drives the line, the receiver runs with a short PWM step.
   sldr_host_model #(.SYM(100)) i_host (.ref_clk(ref_clk), .data_in(data_in));
   sldr_receiver #(.PWM_TICK(13'h0004)) i_dut (.ref_clk(ref_clk), .rst(rst),
      .data_in(data_in), .power_good(power_good), .thermal_shutdown(thermal_shutdown),
      .id_pins(id_pins), .led_on(led_on));

   always #2.5 ref_clk = ~ref_clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Counts on-clocks of every channel over one PWM period; duty n gives 4n clocks.
   task automatic expect_leds();
      logic [15:0] cnt [CHANNELS];
      foreach (cnt[c]) cnt[c] = 16'h0000;
      repeat (PWM_LEN) begin
         @(posedge ref_clk);
         #1;
         foreach (cnt[c]) cnt[c] += 16'(led_on[c] === 1'b1);
      end
      foreach (cnt[c]) check(cnt[c], {7'h00, exp_duty[c], 2'h0});
   endtask

   function automatic logic [7:0] db(input logic [6:0] d);
      return {d, 1'b0};
   endfunction

   // Sends a frame and waits past the next PWM wrap, then judges the outputs.
   task automatic frame(input logic [7:0] b[$], input bit spike);
      i_host.send_frame(b, spike);
      repeat (PWM_LEN + 16) @(posedge ref_clk);
      expect_leds();
   endtask

   task automatic t_power_up();
      frame({MY_ADDR, 8'h00, db(7'h32)}, 1'b0);
      @(posedge ref_clk);
      power_good <= 1'b1;
      repeat (4) @(posedge ref_clk);
      // Settling wait after power good, scaled like the PWM step: 640 steps.
      repeat (PWM_LEN * 5) @(posedge ref_clk);
      $display("test power_up done");
   endtask

   task automatic t_single();
      exp_duty[3] = 7'h64;
      frame({MY_ADDR, 8'h06, db(7'h64)}, 1'b0);
      $display("test single done");
   endtask

   task automatic t_all();
      logic [7:0] q[$];
      q = {MY_ADDR, CMD_ALL};
      for (int c = 0; c < 10; c++) begin
         q.push_back(db(7'(c * 15 + 7)));
      end
      // Each byte up to the ninth sets every channel; the tenth is dropped.
      foreach (exp_duty[c]) exp_duty[c] = 7'((CHANNELS - 1) * 15 + 7);
      frame(q, 1'b0);
      $display("test all_channels done");
   endtask

   task automatic t_addr();
      i_host.send_frame({8'hCA, 8'h00, db(7'h11)}, 1'b0);
      exp_duty[1] = 7'h33;
      frame({MY_ADDR, 8'h02, db(7'h33)}, 1'b0);
      $display("test address done");
   endtask

   task automatic t_partial();
      exp_duty[7] = 7'h05;
      exp_duty[8] = 7'h40;
      frame({MY_ADDR, 8'h0E, db(7'h05), db(7'h40), db(7'h77)}, 1'b0);
      $display("test partial done");
   endtask

   task automatic t_special();
      frame({MY_ADDR, CMD_SPECIAL, db(7'h22), db(7'h22), db(7'h22), db(7'h22)}, 1'b0);
      $display("test special done");
   endtask

   task automatic t_glitch();
      exp_duty[2] = 7'h2A;
      frame({MY_ADDR, 8'h04, db(7'h2A)}, 1'b1);
      $display("test glitch done");
   endtask

   task automatic t_tsd();
      logic [6:0] keep [CHANNELS];
      keep = exp_duty;
      @(posedge ref_clk);
      thermal_shutdown <= 1'b1;
      repeat (2) @(posedge ref_clk);
      foreach (exp_duty[c]) exp_duty[c] = 7'h00;
      expect_leds();
      @(posedge ref_clk);
      thermal_shutdown <= 1'b0;
      repeat (2) @(posedge ref_clk);
      exp_duty = keep;
      expect_leds();
      $display("test shutdown done");
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Main sequence after a five-cycle reset.
   initial begin
      foreach (exp_duty[c]) exp_duty[c] = DUTY_RESET;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      expect_leds();
      t_power_up();
      t_single();
      t_all();
      t_addr();
      t_partial();
      t_special();
      t_glitch();
      t_tsd();
      summarize();
   end

   // Cuts a hang short at 90000 clocks, about 16 percent beyond the expected run length.
   initial begin
      repeat (90000) @(posedge ref_clk);
      n_fail++;
      summarize();
   end
endmodule
`default_nettype wire
